// ---- verilog/sfp_top.sv ----
// Serial flash protection, lock-down, write-protect pin, secure id lock and hold logic.
// Assumes host drives cs_n, sck and shared_io_lines; array and secure id storage live outside.
//
// Overview of operation
// - Array is 4K sectors; eight 8K, two 32K and 126 64K blocks.
// - Power-on leaves single-line mode; a command enters four-line mode.
// - Both clock modes work; idle clock level is the host's concern.
// - Inputs sampled on rising clock; outputs driven after falling clock.
// - Power-on reset leaves every block write-locked.
// - Protection register is 144 bits: pairs for parameter blocks, one otherwise.
// - One means protected; parameter pair upper bit read-lock, lower write-lock.
// - Reads of read-locked parameter blocks return zero bytes.
// - Protection write needs write-enable first; global unlock clears all write-locks not held by permanent lock.
// - Lock-down after write-enable freezes protection until power cycle.
// - Permanent lock register is 136 bits, one per block.
// - Writing one permanently sets lock and forces write-lock; zero does nothing.
// - Permanent lock writes are ignored while lock-down is active.
// - Pin-disable overrides pin-protect-enable; pin acts only in single-line mode.
// - Low pin with enable blocks protection and configuration writes.
// - Lock-down refuses protection writes whatever the pin; config stays writable.
// - Pin guards only registers, never array program or erase.
// - Pin-protect-enable is non-volatile, factory zero.
// - Secure id factory part fixed; user part programmable; lockout blocks writes.
// - Hold works only outside quad mode, with pin-disable clear and chip select low.
// - Hold entry and exit follow the hold input at clock low.
// - Hold tristates output; chip select high resets link logic.
// - Lock-down status reads one after lock-down until power cycle.
// - Pin-disable is configuration bit 1, read/write.
// - Pin-protect-enable is configuration bit 7, read/write.
`include "sfp_defines.svh"
module sfp_top #(
	parameter logic PIN_DISABLE_RST = 1'b0
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic factory_init,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic [3:0] shared_io_lines_in,
	output logic [3:0] shared_io_lines_out,
	output logic [3:0] shared_io_lines_oe,
	input wire logic [22:0] arr_rd_addr,
	input wire logic [7:0] arr_rd_data,
	output logic [7:0] rd_data_out,
	input wire logic [22:0] arr_wr_addr,
	output logic arr_wr_permit,
	output logic sid_wr_req,
	output logic [10:0] sid_wr_addr,
	output logic [7:0] sid_wr_data,
	output logic lockdown_status,
	output logic quad_mode
);
	import sfp_pkg::*;

	// Block address to write-lock bit index of the protection register
	function automatic logic [7:0] wbit(input logic [22:0] a);
		logic [6:0] b;
		b = a[22:16];
		if (b == 7'h00 && !a[15])
			wbit = {5'h00, a[14:13], 1'b0};
		else if (b == 7'h00)
			wbit = 8'h10;
		else if (b == 7'h7F && !a[15])
			wbit = 8'h11;
		else if (b == 7'h7F)
			wbit = {4'h0, 1'b1, a[14:13], 1'b0};
		else
			wbit = 8'h11 + {1'b0, b};
	endfunction

	function automatic logic [7:0] len_of(input logic [7:0] op);
		unique case (op)
			`SFP_OP_WRCFG: len_of = `SFP_LEN_WRCFG;
			`SFP_OP_WRITE_PROTECTION_CMD: len_of = `SFP_LEN_WRITE_PROTECTION_CMD;
			`SFP_OP_WPNV: len_of = `SFP_LEN_WPNV;
			`SFP_OP_PROGRAM_SECURE_ID_CMD: len_of = `SFP_LEN_PROGRAM_SECURE_ID_CMD;
			default: len_of = 8'h00;
		endcase
	endfunction

	function automatic logic is_wr(input logic [7:0] op);
		is_wr = op inside {`SFP_OP_WRITE_ENABLE_CMD, `SFP_OP_WRDI, `SFP_OP_WRCFG, `SFP_OP_WRITE_PROTECTION_CMD,
			`SFP_OP_PROTECTION_LOCKDOWN_CMD, `SFP_OP_ULBPR, `SFP_OP_WPNV, `SFP_OP_EQIO, `SFP_OP_RSTQIO,
			`SFP_OP_PROGRAM_SECURE_ID_CMD, `SFP_OP_LOCKOUT_SECURE_ID_CMD};
	endfunction

	function automatic logic is_rd(input logic [7:0] op);
		is_rd = op inside {`SFP_OP_RDSR, `SFP_OP_RDCR, `SFP_OP_RBPR};
	endfunction

	// System domain state
	logic cs_s1, cs_s2, wp_s1, wp_s2, tg_s1, tg_s2, tg_s3;
	logic wel, pind, ppe, sid_lock;
	logic [`SFP_BPR_W-1:0] bpr_raw, bpr_eff, nv_exp;
	logic [`SFP_NV_W-1:0] nv;
	sfp_snap_s snap;
	// Link domain state
	logic [7:0] cnt, op;
	logic [151:0] sh, next_sh;
	logic [7:0] next_cnt, opc;
	logic fin, complete, tgl, h1, h2, paused, orun;
	logic [`SFP_BPR_W-1:0] osh, next_osh, word;
	sfp_cmd_s cap;

	// Event and level crossings into the system clock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
		end else begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			wp_s1 <= wp_n;
			wp_s2 <= wp_s1;
			tg_s1 <= tgl;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
		end
	end

	logic go, wp_blk, bpr_blk, cfg_ok;
	assign go = tg_s2 ^ tg_s3;
	assign wp_blk = !pind && ppe && !wp_s2 && !quad_mode;
	assign bpr_blk = wp_blk || lockdown_status;
	assign cfg_ok = go && cap.op == `SFP_OP_WRCFG && wel && !wp_blk;

	always_comb begin
		nv_exp = '0;
		for (int p = 0; p < 8; p++)
			nv_exp[2*p] = nv[p];
		for (int k = 0; k < `SFP_BPR_W - 16; k++)
			nv_exp[16+k] = nv[8+k];
	end
	assign bpr_eff = bpr_raw | nv_exp;

	always_ff @(posedge sys_clk) begin
		if (reset)
			wel <= 1'b0;
		else if (go && cap.op == `SFP_OP_WRITE_ENABLE_CMD)
			wel <= 1'b1;
		else if (go && cap.op != `SFP_OP_EQIO && cap.op != `SFP_OP_RSTQIO)
			wel <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			lockdown_status <= 1'b0;
		else if (go && cap.op == `SFP_OP_PROTECTION_LOCKDOWN_CMD && wel)
			lockdown_status <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			bpr_raw <= `SFP_WLOCK_MASK;
		else if (go && wel && !bpr_blk && cap.op == `SFP_OP_WRITE_PROTECTION_CMD)
			bpr_raw <= cap.dat;
		else if (go && wel && !bpr_blk && cap.op == `SFP_OP_ULBPR)
			bpr_raw <= bpr_raw & ~`SFP_WLOCK_MASK;
	end

	// Non-volatile bits survive reset; factory_init loads factory state
	always_ff @(posedge sys_clk) begin
		if (factory_init)
			nv <= '0;
		else if (go && cap.op == `SFP_OP_WPNV && wel && !lockdown_status)
			nv <= nv | cap.dat[`SFP_NV_W-1:0];
	end

	always_ff @(posedge sys_clk) begin
		if (factory_init)
			ppe <= `SFP_PPE_FACTORY;
		else if (cfg_ok)
			ppe <= cap.dat[`SFP_CFG_PPE];
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			pind <= PIN_DISABLE_RST;
		else if (cfg_ok)
			pind <= cap.dat[`SFP_CFG_PIND];
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			quad_mode <= 1'b0;
		else if (go && cap.op == `SFP_OP_EQIO)
			quad_mode <= 1'b1;
		else if (go && cap.op == `SFP_OP_RSTQIO)
			quad_mode <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (factory_init)
			sid_lock <= 1'b0;
		else if (go && cap.op == `SFP_OP_LOCKOUT_SECURE_ID_CMD && wel)
			sid_lock <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sid_wr_req <= 1'b0;
			sid_wr_addr <= 11'h000;
			sid_wr_data <= 8'h00;
		end else begin
			sid_wr_req <= go && cap.op == `SFP_OP_PROGRAM_SECURE_ID_CMD && wel && !sid_lock &&
				cap.dat[23:19] == 5'h00 && cap.dat[18:8] >= `SFP_SID_FACTORY_BYTES;
			sid_wr_addr <= cap.dat[18:8];
			sid_wr_data <= cap.dat[7:0];
		end
	end

	// Array gating: pin plays no part in array writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_data_out <= 8'h00;
			arr_wr_permit <= 1'b0;
		end else begin
			rd_data_out <= (wbit(arr_rd_addr) < 8'h10 && bpr_eff[wbit(arr_rd_addr) + 8'h01]) ?
				8'h00 : arr_rd_data;
			arr_wr_permit <= !bpr_eff[wbit(arr_wr_addr)];
		end
	end

	// Snapshot frozen while chip select is low; link reads it then
	always_ff @(posedge sys_clk) begin
		if (reset)
			snap <= '0;
		else if (cs_s2) begin
			snap.status <= {2'b00, sid_lock, lockdown_status, 2'b00, wel, 1'b0};
			snap.cfg <= {ppe, 3'b000, ~|nv, 1'b0, pind, 1'b0};
			snap.quad <= quad_mode;
			snap.block_protection_bits <= bpr_eff;
		end
	end

	// Link input side, rising clock
	always_comb begin
		next_sh = snap.quad ? {sh[147:0], shared_io_lines_in} : {sh[150:0], shared_io_lines_in[0]};
		next_cnt = cnt + (snap.quad ? 8'h04 : 8'h01);
		opc = (next_cnt == `SFP_OP_BITS) ? next_sh[7:0] : op;
		complete = is_wr(opc) && next_cnt == `SFP_OP_BITS + len_of(opc);
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			cnt <= 8'h00;
			op <= 8'h00;
			sh <= '0;
			fin <= 1'b0;
		end else if (!paused && !fin && !(cnt == `SFP_OP_BITS && is_rd(op))) begin
			sh <= next_sh;
			cnt <= next_cnt;
			if (next_cnt == `SFP_OP_BITS)
				op <= next_sh[7:0];
			if (complete || (next_cnt == `SFP_OP_BITS && !is_rd(next_sh[7:0]) &&
				!is_wr(next_sh[7:0])))
				fin <= 1'b1;
		end
	end

	// Finished command held for the system side; toggle marks it
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			tgl <= 1'b0;
			cap <= '0;
		end else if (!cs_n && !paused && !fin && complete) begin
			tgl <= ~tgl;
			cap <= {opc, next_sh[`SFP_BPR_W-1:0]};
		end
	end

	// Hold input, two falling edges of synchronisation
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			h1 <= 1'b0;
			h2 <= 1'b0;
		end else begin
			h1 <= ~hold_n;
			h2 <= h1;
		end
	end
	assign paused = h2 && !snap.quad && !snap.cfg[`SFP_CFG_PIND];

	// Link output side, falling clock
	always_comb begin
		unique case (op)
			`SFP_OP_RBPR: word = snap.block_protection_bits;
			`SFP_OP_RDSR: word = {18{snap.status}};
			default: word = {18{snap.cfg}};
		endcase
		if (!orun)
			next_osh = word;
		else if (paused)
			next_osh = osh;
		else
			next_osh = snap.quad ? {osh[139:0], 4'h0} : {osh[142:0], 1'b0};
	end

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			orun <= 1'b0;
			osh <= '0;
			shared_io_lines_out <= 4'h0;
			shared_io_lines_oe <= 4'h0;
		end else if (orun || (cnt == `SFP_OP_BITS && is_rd(op))) begin
			orun <= 1'b1;
			osh <= next_osh;
			shared_io_lines_out <= snap.quad ? next_osh[143:140] : {2'b00, next_osh[143], 1'b0};
			shared_io_lines_oe <= paused ? 4'h0 : (snap.quad ? 4'hF : 4'h2);
		end
	end

	// Checks
	default clocking @(posedge sys_clk);
	endclocking

	AST_LOCK_NEEDS_WEL: assert property (disable iff (reset)
		$rose(lockdown_status) |-> $past(wel) && $past(go))
		else $error("lock-down set without write-enable");
	AST_LOCK_STICKY: assert property (disable iff (reset)
		lockdown_status |=> lockdown_status)
		else $error("lock-down status cleared without power cycle");
	AST_BPR_FROZEN: assert property (disable iff (reset)
		lockdown_status && $past(lockdown_status) |-> $stable(bpr_raw))
		else $error("protection changed under lock-down");
	AST_NV_FORCES: assert property (disable iff (reset)
		(bpr_eff & nv_exp) == nv_exp)
		else $error("permanent lock not reflected in write-lock");
	AST_NV_ONLY_SETS: assert property (disable iff (reset || factory_init)
		!$past(factory_init) |-> ($past(nv) & ~nv) == '0)
		else $error("permanent lock bit cleared");
	AST_NV_IGNORED_LOCKED: assert property (disable iff (reset || factory_init)
		lockdown_status ##1 !factory_init |-> $stable(nv))
		else $error("permanent lock written under lock-down");
	AST_CFG_PIN_GUARD: assert property (disable iff (reset || factory_init)
		wp_blk |=> $stable(ppe) && $stable(pind))
		else $error("configuration changed while pin protects");
	AST_RDLOCK_ZERO: assert property (disable iff (reset)
		wbit(arr_rd_addr) < 8'h10 && bpr_eff[wbit(arr_rd_addr) + 8'h01] &&
		$stable(bpr_eff) |=> rd_data_out == 8'h00)
		else $error("read-locked block returned data");
	AST_SID_LOCKED: assert property (disable iff (reset)
		sid_lock |=> !sid_wr_req)
		else $error("secure id write after lockout");
	AST_POR_STATE: assert property (disable iff (reset)
		$fell(reset) |-> bpr_raw == `SFP_WLOCK_MASK && !quad_mode && !lockdown_status)
		else $error("power-on state not protected single-line");
	AST_WEL_CONSUMED: assert property (disable iff (reset)
		go && cap.op == `SFP_OP_WRITE_PROTECTION_CMD |=> !wel)
		else $error("write-enable not cleared by protection write");
endmodule

// ---- verilog/sfp_defines.svh ----
// Constants of the flash protect and hold block: opcodes, bit positions, lengths, reset values.
// Assumes inclusion by the package, the top module and the bench.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_BPR_W 144
`define SFP_NV_W 136
`define SFP_OP_BITS 8'h08
`define SFP_OP_WRITE_ENABLE_CMD 8'h11
`define SFP_OP_WRDI 8'h12
`define SFP_OP_RDSR 8'h13
`define SFP_OP_RDCR 8'h14
`define SFP_OP_WRCFG 8'h15
`define SFP_OP_WRITE_PROTECTION_CMD 8'h16
`define SFP_OP_RBPR 8'h17
`define SFP_OP_PROTECTION_LOCKDOWN_CMD 8'h18
`define SFP_OP_ULBPR 8'h19
`define SFP_OP_WPNV 8'h1A
`define SFP_OP_EQIO 8'h1B
`define SFP_OP_RSTQIO 8'h1C
`define SFP_OP_PROGRAM_SECURE_ID_CMD 8'h1D
`define SFP_OP_LOCKOUT_SECURE_ID_CMD 8'h1E
`define SFP_LEN_WRCFG 8'h10
`define SFP_LEN_WRITE_PROTECTION_CMD 8'h90
`define SFP_LEN_WPNV 8'h88
`define SFP_LEN_PROGRAM_SECURE_ID_CMD 8'h18
`define SFP_CFG_PIND 1
`define SFP_CFG_BPNV 3
`define SFP_CFG_PPE 7
`define SFP_ST_WEL 1
`define SFP_ST_LOCK 4
`define SFP_ST_SID 5
`define SFP_PPE_FACTORY 1'b0
`define SFP_SID_FACTORY_BYTES 11'h008
`define SFP_WLOCK_MASK {128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF, 16'h5555}
`endif

// ---- verilog/sfp_pkg.sv ----
// Types shared by the flash protect and hold block.
// Assumes sfp_defines.svh on the include path.
`include "sfp_defines.svh"
package sfp_pkg;
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] cfg;
		logic quad;
		logic [`SFP_BPR_W-1:0] block_protection_bits;
	} sfp_snap_s;
	typedef struct packed {
		logic [7:0] op;
		logic [`SFP_BPR_W-1:0] dat;
	} sfp_cmd_s;
endpackage

// ---- verification/sfp_host_model.sv ----
// Host-side serial master model for the flash protect block, single-line frames, clock mode 0.
// Assumes the bench calls frame() and leaves at least four system clocks between frames.
module sfp_host_model (
	output logic sck,
	output logic cs_n,
	output logic [3:0] shared_io_lines_in,
	input wire logic [3:0] shared_io_lines_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		shared_io_lines_in = 4'h5;
	end
	// Data changes after falling edge; reply sampled on rising edge
	task automatic put(input logic b, output logic s);
		shared_io_lines_in[0] = b;
		#16 sck = 1'b1;
		s = shared_io_lines_out[1];
		#16 sck = 1'b0;
	endtask
	task automatic frame(input logic [7:0] op, input int n, input logic [143:0] d, input int nrd,
		output logic [7:0] rd);
		logic s;
		cs_n = 1'b0;
		#16;
		for (int i = 7; i >= 0; i--) put(op[i], s);
		for (int i = n - 1; i >= 0; i--) put(d[i], s);
		for (int i = 0; i < nrd; i++) begin
			put(~shared_io_lines_in[0], s);
			rd = {rd[6:0], s};
		end
		#16 cs_n = 1'b1;
		// Released line shows inverse of last value
		shared_io_lines_in = ~shared_io_lines_in;
		#64;
	endtask
endmodule

// ---- verification/serial_flash_protect_hold_tb.sv ----
// Self-checking bench for the flash protect block: frames from the host model, checks at ports.
// Assumes sfp_defines.svh on the include path and the host model compiled before.
`include "sfp_defines.svh"
`define CHK(nm, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("unexpected %s expected %h seen %h", nm, exp, got); \
	end \
end
module serial_flash_protect_hold_tb;
	import sfp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, reset, factory_init, wp_n, hold_n, sck, cs_n;
	logic [3:0] sio_in, sio_out, sio_oe;
	logic [22:0] rd_addr, wr_addr;
	logic [7:0] rd_data, rdv, sid_d;
	logic [10:0] sid_a;
	logic sid_req, permit, lock_st, quad;
	int comparisons = 0;
	int miscompares = 0;
	int sid_cnt = 0;
	logic [143:0] ones = '1;
	sfp_top dut_u (.sys_clk(sys_clk), .reset(reset), .factory_init(factory_init), .sck(sck),
		.cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .shared_io_lines_in(sio_in),
		.shared_io_lines_out(sio_out), .shared_io_lines_oe(sio_oe), .arr_rd_addr(rd_addr),
		.arr_rd_data(8'h5A), .rd_data_out(rd_data), .arr_wr_addr(wr_addr),
		.arr_wr_permit(permit), .sid_wr_req(sid_req), .sid_wr_addr(sid_a),
		.sid_wr_data(sid_d), .lockdown_status(lock_st), .quad_mode(quad));
	sfp_host_model host_u (.sck(sck), .cs_n(cs_n), .shared_io_lines_in(sio_in),
		.shared_io_lines_out(sio_out));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (sid_req === 1'b1) sid_cnt <= sid_cnt + 1;
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input int n, input logic [143:0] d, input int nrd);
		host_u.frame(op, n, d, nrd, rdv);
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic wcmd(input logic [7:0] op, input int n, input logic [143:0] d);
		cmd(`SFP_OP_WRITE_ENABLE_CMD, 0, 0, 0);
		cmd(op, n, d, 0);
	endtask
	task automatic look(input logic [22:0] a, input logic ep, input logic [7:0] ed);
		@(posedge sys_clk);
		wr_addr <= a;
		rd_addr <= a;
		repeat (3) @(posedge sys_clk);
		`CHK("write permit", ep, permit)
		`CHK("read data", ed, rd_data)
	endtask
	task automatic power_cycle(input logic fi);
		@(posedge sys_clk);
		reset <= 1'b1;
		factory_init <= fi;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		factory_init <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	initial begin
		#600000;
		miscompares++;
		wrap_up();
	end
	initial begin
		reset = 1'b1;
		factory_init = 1'b1;
		wp_n = 1'b1;
		hold_n = 1'b1;
		rd_addr = '0;
		wr_addr = '0;
		power_cycle(1'b1);
		`CHK("lockdown", 1'b0, lock_st)
		`CHK("quad", 1'b0, quad)
		look(23'h000000, 1'b0, 8'h5A);
		look(23'h010000, 1'b0, 8'h5A);
		$display("test reset done");
		cmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, 144'h0, 0);
		look(23'h010000, 1'b0, 8'h5A);
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, 144'h2);
		look(23'h010000, 1'b1, 8'h5A);
		look(23'h000000, 1'b1, 8'h00);
		look(23'h002000, 1'b1, 8'h5A);
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, ones);
		look(23'h010000, 1'b0, 8'h5A);
		wcmd(`SFP_OP_ULBPR, 0, 0);
		look(23'h010000, 1'b1, 8'h5A);
		$display("test protection done");
		wcmd(`SFP_OP_WPNV, 136, 144'h1);
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, 144'h0);
		look(23'h000000, 1'b0, 8'h5A);
		look(23'h010000, 1'b1, 8'h5A);
		$display("test permanent lock done");
		wcmd(`SFP_OP_WRCFG, 16, 144'h0080);
		@(posedge sys_clk) wp_n <= 1'b0;
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, ones);
		look(23'h010000, 1'b1, 8'h5A);
		wcmd(`SFP_OP_WRCFG, 16, 144'h0000);
		cmd(`SFP_OP_RDCR, 0, 0, 8);
		`CHK("config", 8'h80, rdv)
		@(posedge sys_clk) wp_n <= 1'b1;
		wcmd(`SFP_OP_WRCFG, 16, 144'h0082);
		cmd(`SFP_OP_RDCR, 0, 0, 8);
		`CHK("config", 8'h82, rdv)
		@(posedge sys_clk) wp_n <= 1'b0;
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, ones);
		look(23'h010000, 1'b0, 8'h5A);
		wcmd(`SFP_OP_ULBPR, 0, 0);
		look(23'h010000, 1'b1, 8'h5A);
		@(posedge sys_clk) wp_n <= 1'b1;
		$display("test write-protect pin done");
		wcmd(`SFP_OP_PROTECTION_LOCKDOWN_CMD, 0, 0);
		`CHK("lockdown", 1'b1, lock_st)
		cmd(`SFP_OP_RDSR, 0, 0, 8);
		`CHK("status", 8'h10, rdv)
		wcmd(`SFP_OP_WRITE_PROTECTION_CMD, 144, ones);
		look(23'h010000, 1'b1, 8'h5A);
		wcmd(`SFP_OP_WPNV, 136, 144'h400);
		power_cycle(1'b0);
		`CHK("lockdown", 1'b0, lock_st)
		wcmd(`SFP_OP_ULBPR, 0, 0);
		look(23'h010000, 1'b1, 8'h5A);
		look(23'h000000, 1'b0, 8'h5A);
		$display("test lock-down done");
		// Long status read paused in its data phase
		fork
			cmd(`SFP_OP_RDSR, 0, 0, 40);
			begin
				repeat (50) @(posedge sys_clk);
				`CHK("read enable", 4'h2, sio_oe)
				hold_n <= 1'b0;
				repeat (20) @(posedge sys_clk);
				`CHK("hold enable", 4'h0, sio_oe)
				hold_n <= 1'b1;
				repeat (20) @(posedge sys_clk);
				`CHK("resume enable", 4'h2, sio_oe)
			end
		join
		$display("test hold done");
		wcmd(`SFP_OP_PROGRAM_SECURE_ID_CMD, 24, 144'h0010A5);
		`CHK("sid count", 1, sid_cnt)
		`CHK("sid addr", 11'h010, sid_a)
		`CHK("sid data", 8'hA5, sid_d)
		wcmd(`SFP_OP_PROGRAM_SECURE_ID_CMD, 24, 144'h000411);
		`CHK("sid count", 1, sid_cnt)
		wcmd(`SFP_OP_LOCKOUT_SECURE_ID_CMD, 0, 0);
		wcmd(`SFP_OP_PROGRAM_SECURE_ID_CMD, 24, 144'h00205A);
		`CHK("sid count", 1, sid_cnt)
		$display("test secure id done");
		cmd(`SFP_OP_EQIO, 0, 0, 0);
		`CHK("quad", 1'b1, quad)
		$display("test quad done");
		wrap_up();
	end
endmodule
